/* rtl/hai_decode.sv */
// host address decode, memory windows and indirect io window
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - memory hits in register window go to internal target at window offset
// - flash window answers only when flash enabled and its base nonzero
// - offset into flash window is the physical flash address
// - expansion rom window reaches flash only when enabled and base nonzero
// - io cycles claimed only with nonzero io base and io decode enabled
// - io window is 32 bytes: pointer at offset 0, data port at 4
// - pointer 0-1FFFF internal, 20000-7FFFF undefined, 80000-FFFFF flash
// - pointer writes narrower than a full dword are discarded
// - pointer reads return the whole dword whatever the byte enables
// - pointer bits 31..20 ignore writes and read zero
// - pointer clears on either reset and holds until written
// - internal data port writes must be full dword, others ignored
// - flash data port writes of 8, 16, 32 bits when aligned
// - data port is 32 bits wide, reads return a full dword
// - accesses finish at once unless target stalls, then wait
// - narrow register writes ignored, partial register reads full
module hai_decode
    import hai_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic power_good_reset,
    input wire hai_cfg_s cfg,
    input wire logic host_req,
    input wire hai_req_s host_cmd,
    output logic host_ready,
    output logic host_ack,
    output logic host_hit,
    output logic [31:0] host_rdata,
    output logic int_req,
    output hai_tgt_s int_cmd,
    input wire logic int_ack,
    input wire logic [31:0] int_rdata,
    output logic flash_req,
    output hai_tgt_s flash_cmd,
    input wire logic flash_ack,
    input wire logic [31:0] flash_rdata
);
    hai_st_s s_r;
    hai_st_s s_nxt;
    logic tkn;
    logic full;
    logic io_hit;
    logic reg_hit;
    logic fl_hit;
    logic rom_hit;
    logic ofs_ptr;
    logic ofs_data;
    logic ptr_int;
    logic ptr_flash;

    // a new request is only taken while idle; busy acts as retry
    assign host_ready = (s_r.st == ST_IDLE);
    assign tkn = host_req && host_ready;
    assign full = (host_cmd.be_n == BE_FULL);

    // io claim needs base and decode enable
    assign io_hit = host_cmd.is_io && cfg.io_en && (cfg.io_base != '0)
        && (host_cmd.addr[31:IO_WIN_BITS] == cfg.io_base[31:IO_WIN_BITS]);
    assign reg_hit = !host_cmd.is_io
        && (host_cmd.addr[31:REG_WIN_BITS] == cfg.reg_base[31:REG_WIN_BITS]);
    // flash window gated by enable and nonzero base
    assign fl_hit = !host_cmd.is_io && cfg.flash_en && (cfg.flash_base != '0)
        && (host_cmd.addr[31:FLASH_WIN_BITS] == cfg.flash_base[31:FLASH_WIN_BITS]);
    // rom window gated the same way
    assign rom_hit = !host_cmd.is_io && cfg.rom_en && (cfg.rom_base != '0)
        && (host_cmd.addr[31:FLASH_WIN_BITS] == cfg.rom_base[31:FLASH_WIN_BITS]);
    // dword index inside the io window
    assign ofs_ptr = (host_cmd.addr[4:2] == IO_PTR_OFS[4:2]);
    assign ofs_data = (host_cmd.addr[4:2] == IO_DATA_OFS[4:2]);
    assign ptr_int = (s_r.ptr <= PTR_INT_LAST);
    assign ptr_flash = (s_r.ptr >= PTR_FLASH_FIRST);

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (host_req) begin
                    s_nxt.ack = 1'b1;
                    s_nxt.hit = 1'b1;
                    s_nxt.rdata = RDATA_NONE;
                    s_nxt.tgt.we = host_cmd.we;
                    s_nxt.tgt.wdata = host_cmd.wdata;
                    s_nxt.tgt.be_n = host_cmd.be_n;
                    if (io_hit) begin
                        if (ofs_ptr) begin
                            if (host_cmd.we) begin
                                if (full) begin
                                    s_nxt.ptr = host_cmd.wdata[PTR_BITS-1:0];
                                end
                            end else begin
                                s_nxt.rdata = {PTR_UPPER, s_r.ptr};
                            end
                        end else if (ofs_data) begin
                            // pointer used as is, not advanced
                            if (ptr_int) begin
                                if (!host_cmd.we || full) begin
                                    s_nxt.st = ST_INT;
                                    s_nxt.ack = 1'b0;
                                    s_nxt.ireq = 1'b1;
                                    s_nxt.tgt.be_n = BE_FULL;
                                    s_nxt.tgt.addr = {3'h0, s_r.ptr[REG_WIN_BITS-1:0]};
                                end
                            end else if (ptr_flash) begin
                                if (!host_cmd.we || hai_lane_ok(host_cmd.be_n, s_r.ptr[1:0])) begin
                                    s_nxt.st = ST_FLASH;
                                    s_nxt.ack = 1'b0;
                                    s_nxt.freq = 1'b1;
                                    s_nxt.tgt.addr = {1'b0, s_r.ptr[FLASH_WIN_BITS-1:0]};
                                end
                            end
                            // undefined pointer range: answered, nothing moves
                        end
                    end else if (reg_hit) begin
                        // narrow register writes dropped, reads full
                        if (!host_cmd.we || full) begin
                            s_nxt.st = ST_INT;
                            s_nxt.ack = 1'b0;
                            s_nxt.ireq = 1'b1;
                            s_nxt.tgt.be_n = BE_FULL;
                            s_nxt.tgt.addr = {3'h0, host_cmd.addr[REG_WIN_BITS-1:0]};
                        end
                    end else if (fl_hit || rom_hit) begin
                        // window offset is the flash address
                        s_nxt.st = ST_FLASH;
                        s_nxt.ack = 1'b0;
                        s_nxt.freq = 1'b1;
                        s_nxt.tgt.addr = {1'b0, host_cmd.addr[FLASH_WIN_BITS-1:0]};
                    end else begin
                        s_nxt.hit = 1'b0;
                    end
                end
            end
            ST_INT: begin
                if (int_ack) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.ireq = 1'b0;
                    s_nxt.ack = 1'b1;
                    s_nxt.rdata = s_r.tgt.we ? RDATA_NONE : int_rdata;
                end
            end
            ST_FLASH: begin
                if (flash_ack) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.freq = 1'b0;
                    s_nxt.ack = 1'b1;
                    s_nxt.rdata = s_r.tgt.we ? RDATA_NONE : flash_rdata;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst or posedge power_good_reset) begin
        if (rst || power_good_reset) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign host_ack = s_r.ack;
    assign host_hit = s_r.hit;
    assign host_rdata = s_r.rdata;
    assign int_req = s_r.ireq;
    assign int_cmd = s_r.tgt;
    assign flash_req = s_r.freq;
    assign flash_cmd = s_r.tgt;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || power_good_reset);

    logic io_ptr_acc;
    logic io_data_acc;
    assign io_ptr_acc = tkn && io_hit && ofs_ptr;
    assign io_data_acc = tkn && io_hit && ofs_data;

    property p_ptr_narrow;
        io_ptr_acc && host_cmd.we && !full |=> $stable(s_r.ptr) && host_ack;
    endproperty
    a_ptr_narrow: assert property (p_ptr_narrow) else $error("narrow pointer write landed");

    property p_ptr_write;
        io_ptr_acc && host_cmd.we && full |=> s_r.ptr == $past(host_cmd.wdata[19:0]);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

    property p_ptr_read;
        io_ptr_acc && !host_cmd.we |=> host_ack && host_hit
            && host_rdata == {PTR_UPPER, $past(s_r.ptr)};
    endproperty
    a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong");

    property p_ptr_reset;
        $past(rst || power_good_reset) |-> s_r.ptr == PTR_RST;
    endproperty
    a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not cleared");

    property p_io_off;
        tkn && host_cmd.is_io && (!cfg.io_en || cfg.io_base == '0) |=> host_ack && !host_hit
            && !int_req && !flash_req;
    endproperty
    a_io_off: assert property (p_io_off) else $error("io claimed while disabled");

    property p_flash_off;
        tkn && !host_cmd.is_io && !reg_hit && !rom_hit && (!cfg.flash_en || cfg.flash_base == '0)
            |=> !flash_req && !host_hit;
    endproperty
    a_flash_off: assert property (p_flash_off) else $error("flash reached while gated");

    property p_reg_route;
        tkn && !io_hit && reg_hit && !host_cmd.we |=> int_req
            && int_cmd.addr[16:0] == $past(host_cmd.addr[16:0]) && int_cmd.be_n == BE_FULL;
    endproperty
    a_reg_route: assert property (p_reg_route) else $error("register read misrouted");

    property p_flash_route;
        tkn && !io_hit && !reg_hit && fl_hit |=> flash_req
            && flash_cmd.addr[18:0] == $past(host_cmd.addr[18:0]);
    endproperty
    a_flash_route: assert property (p_flash_route) else $error("flash offset wrong");

    property p_data_narrow;
        io_data_acc && ptr_int && host_cmd.we && !full |=> host_ack && !int_req;
    endproperty
    a_data_narrow: assert property (p_data_narrow) else $error("narrow data write passed");

    property p_hold;
        int_req && !int_ack |=> int_req && !host_ack;
    endproperty
    a_hold: assert property (p_hold) else $error("internal wait dropped");

    property p_no_inc;
        io_data_acc |=> $stable(s_r.ptr);
    endproperty
    a_no_inc: assert property (p_no_inc) else $error("pointer moved on data access");

    property p_undef;
        io_data_acc && !ptr_int && !ptr_flash |=> host_ack && !int_req && !flash_req;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined range reached a target");

    property p_rom_route;
        tkn && !io_hit && !reg_hit && !fl_hit && rom_hit |=> flash_req
            && flash_cmd.addr[18:0] == $past(host_cmd.addr[18:0]);
    endproperty
    a_rom_route: assert property (p_rom_route) else $error("rom offset wrong");

    property p_rom_off;
        tkn && !host_cmd.is_io && !reg_hit && !fl_hit && (!cfg.rom_en || cfg.rom_base == '0)
            |=> !flash_req && !host_hit;
    endproperty
    a_rom_off: assert property (p_rom_off) else $error("rom reached while gated");

    property p_io_spare;
        tkn && io_hit && !ofs_ptr && !ofs_data |=> host_ack && host_hit
            && host_rdata == RDATA_NONE && !int_req && !flash_req;
    endproperty
    a_io_spare: assert property (p_io_spare) else $error("spare io offset misbehaved");

    // flash lanes checked against the pointer
    property p_lane_bad;
        io_data_acc && ptr_flash && host_cmd.we && !hai_lane_ok(host_cmd.be_n, s_r.ptr[1:0])
            |=> host_ack && !flash_req;
    endproperty
    a_lane_bad: assert property (p_lane_bad) else $error("bad flash lanes passed");

    property p_lane_ok;
        io_data_acc && ptr_flash && host_cmd.we && hai_lane_ok(host_cmd.be_n, s_r.ptr[1:0])
            |=> flash_req && flash_cmd.be_n == $past(host_cmd.be_n)
            && flash_cmd.addr == {1'b0, $past(s_r.ptr[18:0])};
    endproperty
    a_lane_ok: assert property (p_lane_ok) else $error("aligned flash write lost");

    property p_int_data;
        int_req && int_ack && !int_cmd.we |=> host_ack && host_rdata == $past(int_rdata);
    endproperty
    a_int_data: assert property (p_int_data) else $error("internal read data lost");

    property p_flash_data;
        flash_req && flash_ack && !flash_cmd.we
            |=> host_ack && host_rdata == $past(flash_rdata);
    endproperty
    a_flash_data: assert property (p_flash_data) else $error("flash read data lost");

    // busy exactly while a target is owed
    property p_ready;
        host_ready == !(int_req || flash_req);
    endproperty
    a_ready: assert property (p_ready) else $error("ready out of step with targets");

    property p_flash_hold;
        flash_req && !flash_ack |=> flash_req && !host_ack;
    endproperty
    a_flash_hold: assert property (p_flash_hold) else $error("flash wait dropped");

    // a target may sample its command on any cycle of the wait
    property p_icmd_hold;
        int_req && !int_ack |=> $stable(int_cmd);
    endproperty
    a_icmd_hold: assert property (p_icmd_hold) else $error("internal command moved");

    property p_fcmd_hold;
        flash_req && !flash_ack |=> $stable(flash_cmd);
    endproperty
    a_fcmd_hold: assert property (p_fcmd_hold) else $error("flash command moved");

    property p_mem_narrow;
        tkn && !io_hit && reg_hit && host_cmd.we && !full |=> host_ack && !int_req;
    endproperty
    a_mem_narrow: assert property (p_mem_narrow) else $error("narrow reg write passed");

    // data port follows the pointer as it stands
    property p_data_int;
        io_data_acc && ptr_int && !host_cmd.we |=> int_req
            && int_cmd.addr == {3'h0, $past(s_r.ptr[16:0])};
    endproperty
    a_data_int: assert property (p_data_int) else $error("data port missed pointer");

    property p_data_flash;
        io_data_acc && ptr_flash && !host_cmd.we |=> flash_req
            && flash_cmd.addr == {1'b0, $past(s_r.ptr[18:0])};
    endproperty
    a_data_flash: assert property (p_data_flash) else $error("flash port off pointer");

    c_ptr_write: cover property (io_ptr_acc && host_cmd.we && full);
    c_flash_byte: cover property (io_data_acc && ptr_flash && host_cmd.we && host_cmd.be_n == 4'hD);
    c_int_stall: cover property (int_req && !int_ack ##1 int_req && int_ack);
    c_rom_read: cover property (tkn && rom_hit && !fl_hit && !reg_hit);
    c_undef: cover property (io_data_acc && !ptr_int && !ptr_flash);
endmodule : hai_decode
`default_nettype wire

/* common/hai_pkg.sv */
// constants and carrier types for the host decode and io window
package hai_pkg;
    localparam int REG_WIN_BITS = 17;
    localparam int FLASH_WIN_BITS = 19;
    localparam int IO_WIN_BITS = 5;
    localparam int PTR_BITS = 20;
    localparam logic [4:0] IO_PTR_OFS = 5'h00;
    localparam logic [4:0] IO_DATA_OFS = 5'h04;
    localparam logic [19:0] PTR_RST = 20'h0_0000;
    localparam logic [19:0] PTR_INT_LAST = 20'h1_FFFF;
    localparam logic [19:0] PTR_FLASH_FIRST = 20'h8_0000;
    localparam logic [11:0] PTR_UPPER = 12'h000;
    localparam logic [3:0] BE_FULL = 4'h0;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    typedef struct packed {
        logic is_io;
        logic we;
        logic [31:0] addr;
        logic [3:0] be_n;
        logic [31:0] wdata;
    } hai_req_s;

    typedef struct packed {
        logic we;
        logic [19:0] addr;
        logic [3:0] be_n;
        logic [31:0] wdata;
    } hai_tgt_s;

    typedef struct packed {
        logic [31:0] reg_base;
        logic [31:0] flash_base;
        logic [31:0] rom_base;
        logic [31:0] io_base;
        logic io_en;
        logic flash_en;
        logic rom_en;
    } hai_cfg_s;

    typedef enum logic [1:0] {ST_IDLE, ST_INT, ST_FLASH} hai_state_e;

    typedef struct packed {
        hai_state_e st;
        logic [19:0] ptr;
        logic ack;
        logic hit;
        logic [31:0] rdata;
        logic ireq;
        logic freq;
        hai_tgt_s tgt;
    } hai_st_s;

    localparam hai_st_s ST_RESET = '0;

    // flash lanes must agree with the pointer's low bits
    function automatic logic hai_lane_ok(input logic [3:0] be_n, input logic [1:0] lo);
        logic ok;
        ok = 1'b0;
        unique case (be_n)
            4'hE: ok = (lo == 2'h0);
            4'hD: ok = (lo == 2'h1);
            4'hB: ok = (lo == 2'h2);
            4'h7: ok = (lo == 2'h3);
            4'hC: ok = (lo == 2'h0);
            4'h3: ok = (lo == 2'h2);
            4'h0: ok = (lo == 2'h0);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : hai_lane_ok
endpackage : hai_pkg

/* sim/hai_host_model.sv */
// host bridge model issuing io and memory cycles
`timescale 1ns/1ps
`default_nettype none
module hai_host_model
    import hai_pkg::*;
(
    input wire logic sys_clk,
    input wire logic host_ready,
    input wire logic host_ack,
    input wire logic host_hit,
    input wire logic [31:0] host_rdata,
    output var logic host_req,
    output var hai_req_s host_cmd
);
    initial begin
        host_req = 1'b0;
        host_cmd = '0;
    end
    // lanes and pointer not checked here; the caller may mismatch them on purpose
    // a hang in either wait is caught by the bench's cycle ceiling
    task automatic cyc(input hai_req_s c, output logic [31:0] rd, output logic h);
        @(negedge sys_clk);
        host_req = 1'b1;
        host_cmd = c;
        while (host_ready !== 1'b1) begin
            @(negedge sys_clk);
        end
        @(negedge sys_clk);
        host_req = 1'b0;
        // released lines must not keep the old value
        host_cmd = ~c;
        while (host_ack !== 1'b1) begin
            @(negedge sys_clk);
        end
        rd = host_rdata;
        h = host_hit;
    endtask : cyc
endmodule : hai_host_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the host decode and io window
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hai_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, power_good_reset = 1'b0;
    hai_cfg_s cfg;
    logic host_req, host_ready, host_ack, host_hit, int_req, int_ack, flash_req, flash_ack;
    hai_req_s host_cmd;
    hai_tgt_s int_cmd, flash_cmd;
    logic [31:0] host_rdata, int_rdata, flash_rdata, rd, a, d;
    logic [31:0] imem [0:32767];
    logic [31:0] fmem [0:131071];
    logic h;
    // byte lanes paired with pointer low bits
    logic [3:0] lanes [0:6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h3, 4'h0};
    logic [1:0] los [0:6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0};
    int seed = 83, wi = 0, wf = 0, num_errors = 0, comparisons = 0, cycles = 0;
    hai_decode uut (.sys_clk(sys_clk), .rst(rst), .power_good_reset(power_good_reset),
        .cfg(cfg), .host_req(host_req), .host_cmd(host_cmd), .host_ready(host_ready),
        .host_ack(host_ack), .host_hit(host_hit), .host_rdata(host_rdata),
        .int_req(int_req), .int_cmd(int_cmd), .int_ack(int_ack), .int_rdata(int_rdata),
        .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata));
    hai_host_model host (.sys_clk(sys_clk), .host_ready(host_ready), .host_ack(host_ack),
        .host_hit(host_hit), .host_rdata(host_rdata), .host_req(host_req),
        .host_cmd(host_cmd));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // targets stall 0..3 cycles at random; idle read lines carry noise
    always @(negedge sys_clk) begin
        int_ack <= 1'b0;
        flash_ack <= 1'b0;
        int_rdata <= $random(seed);
        flash_rdata <= $random(seed);
        if (int_req && !int_ack) begin
            if (wi == 0) begin
                int_ack <= 1'b1;
                int_rdata <= imem[int_cmd.addr[16:2]];
                if (int_cmd.we) imem[int_cmd.addr[16:2]] = int_cmd.wdata;
                wi = $random(seed) & 3;
            end else wi--;
        end
        if (flash_req && !flash_ack) begin
            if (wf == 0) begin
                flash_ack <= 1'b1;
                flash_rdata <= fmem[flash_cmd.addr[18:2]];
                if (flash_cmd.we) fmem[flash_cmd.addr[18:2]] =
                    lane_mix(fmem[flash_cmd.addr[18:2]], flash_cmd.wdata, flash_cmd.be_n);
                wf = $random(seed) & 3;
            end else wf--;
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            conclude();
        end
    end
    function automatic logic [31:0] lane_mix(logic [31:0] o, logic [31:0] n, logic [3:0] be_n);
        for (int b = 0; b < 4; b++) if (!be_n[b]) o[8*b+:8] = n[8*b+:8];
        return o;
    endfunction : lane_mix
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic io, input logic w, input logic [31:0] ad,
        input logic [3:0] be, input logic [31:0] wd);
        host.cyc(hai_req_s'{io, w, ad, be, wd}, rd, h);
    endtask : acc
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial begin
        cfg = '{32'h1000_0000, 32'h2000_0000, 32'h3008_0000, 32'h0000_0100, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 131072; i++) fmem[i] = 32'h0000_0000;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        acc(1, 0, 32'h0000_0100, 4'h7, 32'h0);
        chk(rd, 32'h0000_0000);
        acc(1, 1, 32'h0000_0100, 4'h0, 32'hFFF2_3454);
        acc(1, 1, 32'h0000_0100, 4'hC, 32'h0000_1110);
        acc(1, 0, 32'h0000_0100, 4'hE, 32'h0);
        chk(rd, 32'h0002_3454);
        power_good_reset = 1'b1;
        @(negedge sys_clk);
        power_good_reset = 1'b0;
        acc(1, 0, 32'h0000_0100, 4'h0, 32'h0);
        chk(rd, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            a = $random(seed) & 32'h0001_FFFC;
            d = $random(seed);
            acc(0, 1, 32'h1000_0000 | a, 4'h0, d);
            acc(0, 1, 32'h1000_0000 | a, 4'h1, ~d);
            acc(1, 1, 32'h0000_0100, 4'h0, a);
            acc(1, 1, 32'h0000_0104, 4'h3, ~d);
            acc(1, 0, 32'h0000_0104, 4'hE, 32'h0);
            chk(rd, d);
            acc(1, 0, 32'h0000_0100, 4'h0, 32'h0);
            chk(rd, a);
            acc(0, 0, 32'h1000_0000 | a, 4'hC, 32'h0);
            chk(rd, d);
            acc(1, 1, 32'h0000_0104, 4'h0, ~d);
            acc(0, 0, 32'h1000_0000 | a, 4'h0, 32'h0);
            chk(rd, ~d);
        end
        for (int i = 0; i < 7; i++) begin
            acc(1, 1, 32'h0000_0100, 4'h0, 32'h0008_0000 + i * 4 + los[i]);
            acc(1, 1, 32'h0000_0104, lanes[i], 32'hA5C3_7E19);
            acc(0, 0, 32'h2000_0000 + i * 4, 4'h0, 32'h0);
            chk(rd, lane_mix(32'h0, 32'hA5C3_7E19, lanes[i]));
        end
        acc(1, 1, 32'h0000_0100, 4'h0, 32'h0008_0041);
        acc(1, 1, 32'h0000_0104, 4'hE, 32'hFFFF_FFFF);
        acc(0, 0, 32'h2000_0040, 4'h0, 32'h0);
        chk(rd, 32'h0000_0000);
        acc(1, 1, 32'h0000_0100, 4'h0, 32'h0008_0004);
        acc(1, 0, 32'h0000_0104, 4'hD, 32'h0);
        chk(rd, lane_mix(32'h0, 32'hA5C3_7E19, lanes[1]));
        acc(0, 0, 32'h3008_0000, 4'h0, 32'h0);
        chk(rd, 32'h0000_0019);
        acc(0, 1, 32'h2000_0080, 4'h0, d);
        acc(0, 0, 32'h3008_0080, 4'h0, 32'h0);
        chk(rd, d);
        acc(1, 1, 32'h0000_0100, 4'h0, 32'h0004_0000);
        acc(1, 0, 32'h0000_0104, 4'h0, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, h}, 32'h0000_0001);
        acc(1, 0, 32'h0000_0108, 4'h0, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, h}, 32'h0000_0001);
        cfg.flash_en = 1'b0;
        acc(0, 0, 32'h2000_0000, 4'h0, 32'h0);
        chk({31'h0, h}, 32'h0000_0000);
        cfg.flash_en = 1'b1;
        cfg.flash_base = 32'h0000_0000;
        acc(0, 0, 32'h0000_0000, 4'h0, 32'h0);
        chk({31'h0, h}, 32'h0000_0000);
        cfg.rom_en = 1'b0;
        acc(0, 0, 32'h3008_0000, 4'h0, 32'h0);
        chk({31'h0, h}, 32'h0000_0000);
        cfg.io_en = 1'b0;
        acc(1, 0, 32'h0000_0100, 4'h0, 32'h0);
        chk({31'h0, h}, 32'h0000_0000);
        cfg.io_en = 1'b1;
        cfg.io_base = 32'h0000_0000;
        acc(1, 0, 32'h0000_0000, 4'h0, 32'h0);
        chk({31'h0, h}, 32'h0000_0000);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
